// [pkg/asc_pkg.sv]
// constants, register map and types for the conversion sequence controller
package asc_pkg;
  // ---------------------------------------------------------------------------
  // register word indices (avalon word address)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] IDX_CONFIG     = 4'h0; // fifo, fast clear, test mode
  localparam logic [3:0] IDX_CONTROL4   = 4'h1; // converter_control_four
  localparam logic [3:0] IDX_SELECT     = 4'h2; // conversion_select_control
  localparam logic [3:0] IDX_STATUS     = 4'h3; // conversion_status
  localparam logic [3:0] IDX_RESULT0    = 4'h8; // result_register_zero .. seven

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CFG_FIFO_BIT   = 0;
  localparam int CFG_FAST_BIT   = 1;
  localparam int CFG_TEST_BIT   = 2;
  localparam int SEL_CODE_LSB   = 0; // channel_code_bit0..bit2
  localparam int SEL_SPECIAL    = 3;
  localparam int SEL_MULTI      = 4;
  localparam int SEL_SCAN       = 5;
  localparam int SEL_EIGHT      = 6;
  localparam int SEL_SINGLE     = 7;
  localparam int STAT_CNT_LSB   = 8;
  localparam int STAT_SCF_BIT   = 15;

  // ---------------------------------------------------------------------------
  // reset values and special channel codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_RESULT   = 16'h0000;
  localparam logic [2:0]  RST_COUNT    = 3'h0;
  localparam logic [2:0]  SPC_HIGH     = 3'h4; // high_reference
  localparam logic [2:0]  SPC_LOW      = 3'h5; // low_reference
  localparam logic [2:0]  SPC_MID      = 3'h6; // midpoint of references
  localparam logic [7:0]  EXP_HIGH     = 8'hFF; // expected 8-bit codes
  localparam logic [7:0]  EXP_LOW      = 8'h00;
  localparam logic [7:0]  EXP_MID      = 8'h7F;
  localparam logic [3:0]  LEN_ONE      = 4'h1;
  localparam logic [3:0]  LEN_FOUR     = 4'h4;
  localparam logic [3:0]  LEN_EIGHT    = 4'h8;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_WAIT  = 3'b100
  } asc_state_e;
endpackage : asc_pkg

// [hdl/asc_chan_map.sv]
// channel code decoder: external input one-hot or internal reference source
`timescale 1ns/10ps
module asc_chan_map (
  input  wire logic [2:0] code,
  input  wire logic       special,
  output logic      [7:0] ext_onehot,
  output logic            ref_high,
  output logic            ref_low,
  output logic            ref_mid,
  output logic            reserved
);
  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  // normal mode: code is the external input index directly [R04]
  assign ext_onehot = special ? 8'h00 : (8'h01 << code);
  // special mode: code picks an internal source [R05] [R06]
  assign ref_high   = special & (code == asc_pkg::SPC_HIGH);
  assign ref_low    = special & (code == asc_pkg::SPC_LOW);
  assign ref_mid    = special & (code == asc_pkg::SPC_MID);
  // 0xx and 111 are reserved special codes [R06] [R09]
  assign reserved   = special & ~(ref_high | ref_low | ref_mid);
endmodule : asc_chan_map

// [hdl/asc_seq_top.sv]
// conversion sequence controller with avalon-mm register slave
//
// Operation
// R01: single mode converts only the coded channel
// R02: multi mode: start code, then increment
// R03: channel code wraps from seven to zero
// R04: normal code is external input index
// R05: special bit selects internal test source
// R06: special 100 high, 101 low, 110 mid
// R07: conversion k to result k, channel start+k
// R08: software keeps single bit clear for four
// R09: special multi steps high, low, mid; reserved
// R10: single channel: four or eight same conversions
// R11: eight 0, single 1: one conversion
// R12: software writes zero to legacy-masked code bits
// R13: status registers ignore writes normally
// R14: sequence flag sets at each sequence end
// R15: sequence flag clear: restart or result read; the code clears it on a result read only in fast clear mode
// R16: result counter points, resets per sequence
// R17: fifo mode keeps counter, wraps at seven
// R18: complete flag k set with result k
// R19: normal clear needs status read first
// R20: fast clear: result read clears flag
// R21: complete flags writable only in test mode
// R22: control write clears all flags, cancels request
// R23: control write aborts and starts new sequence
// R24: length: 00 four, 01 one, 1x eight
// R25: scan restarts sequence, else return idle
`timescale 1ns/10ps
module asc_seq_top #(
  parameter int RES_W = 16 // width of one conversion result
) (
  input  wire logic             CLK,
  input  wire logic             RST_B,
  input  wire logic [3:0]       AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  output logic      [31:0]      AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  output logic                  CONV_START,
  output logic                  CONV_ABORT,
  output logic      [2:0]       CONV_CHANNEL,
  output logic      [7:0]       CONV_EXT_SELECT,
  output logic                  CONV_REF_HIGH,
  output logic                  CONV_REF_LOW,
  output logic                  CONV_REF_MID,
  output logic                  CONV_RESERVED,
  input  wire logic             CONV_DONE,
  input  wire logic [RES_W-1:0] CONV_DATA,
  output logic                  SEQ_BUSY
);
  // ---------------------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------------------
  // sequence length from eight and single bits
  function automatic logic [3:0] seq_len(input logic eight, input logic single);
    seq_len = eight ? asc_pkg::LEN_EIGHT : (single ? asc_pkg::LEN_ONE : asc_pkg::LEN_FOUR);
  endfunction : seq_len

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  asc_pkg::asc_state_e state_ff, nxt_state;   // sequencer state
  logic [7:0]       cfg_ff;                   // fifo / fast clear / test mode
  logic [7:0]       ctl4_ff;                  // stored only, write restarts
  logic [7:0]       sel_ff;                   // channel and sequence select
  logic [7:0]       ccf_ff, nxt_ccf;          // conversion_complete_flags
  logic [7:0]       armed_ff, nxt_armed;      // status read seen per flag
  logic             scf_ff, nxt_scf;          // sequence_complete_flag
  logic [2:0]       cnt_ff, nxt_cnt;          // result_counter
  logic [2:0]       pos_ff, nxt_pos;          // position inside sequence
  logic [RES_W-1:0] res_mem [8];              // result registers
  logic [31:0]      rdata_ff;                 // read data, valid on answer
  logic             ack_ff;                   // second bus cycle marker
  logic             start_ff;                 // conversion start pulse
  logic             abort_ff;                 // abort pulse to analog side
  logic [2:0]       chan_ff;                  // channel code of conversion

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  wire        bus_req    = AVS_READ | AVS_WRITE;
  // every access answers on its second cycle
  wire        bus_take   = bus_req & ack_ff;
  wire        wr_take    = AVS_WRITE & ack_ff;
  wire        rd_take    = AVS_READ & ack_ff;
  wire        hit_cfg    = AVS_ADDRESS == asc_pkg::IDX_CONFIG;
  wire        hit_ctl4   = AVS_ADDRESS == asc_pkg::IDX_CONTROL4;
  wire        hit_sel    = AVS_ADDRESS == asc_pkg::IDX_SELECT;
  wire        hit_stat   = AVS_ADDRESS == asc_pkg::IDX_STATUS;
  wire        hit_res    = AVS_ADDRESS[3] == asc_pkg::IDX_RESULT0[3];
  wire [2:0]  res_idx    = AVS_ADDRESS[2:0];
  wire        fifo_mode  = cfg_ff[asc_pkg::CFG_FIFO_BIT];
  wire        fast_clear = cfg_ff[asc_pkg::CFG_FAST_BIT];
  wire        test_mode  = cfg_ff[asc_pkg::CFG_TEST_BIT];
  // writing either control register restarts the sequence [R23]
  wire        restart    = wr_take & (hit_ctl4 | hit_sel);
  wire        res_rd     = rd_take & hit_res;
  // normal clear: any later result access after a status read [R19]
  wire        res_acc    = bus_take & hit_res;
  wire        stat_rd    = rd_take & hit_stat;
  // status takes a write only in test mode, otherwise ignored [R13] [R21]
  wire        stat_wr    = wr_take & hit_stat & test_mode;
  wire        done_ev    = CONV_DONE & state_ff[2];
  wire [3:0]  len        = seq_len(sel_ff[asc_pkg::SEL_EIGHT], sel_ff[asc_pkg::SEL_SINGLE]); // [R24]
  wire        last_conv  = ({1'b0, pos_ff} + 4'h1) == len;
  wire        multi      = sel_ff[asc_pkg::SEL_MULTI];
  wire [2:0]  base_code  = sel_ff[asc_pkg::SEL_CODE_LSB +: 3];
  // multi: start code plus position, three bits wrap modulo eight [R02] [R03] [R07] [R09]
  // single: same coded channel every conversion [R01] [R10] [R11]
  wire [2:0]  conv_code  = multi ? 3'(base_code + pos_ff) : base_code;
  wire [7:0]  clr_mask   = fast_clear ? (res_rd ? (8'h01 << res_idx) : 8'h00)
                                      : (res_acc ? ((8'h01 << res_idx) & armed_ff) : 8'h00);
  wire [7:0]  set_mask   = done_ev ? (8'h01 << cnt_ff) : 8'h00;
  wire [31:0] stat_word  = {16'h0000, scf_ff, 4'h0, cnt_ff, ccf_ff};
  wire [31:0] rd_mux     = hit_cfg  ? {24'h0, cfg_ff}  :
                           hit_ctl4 ? {24'h0, ctl4_ff} :
                           hit_sel  ? {24'h0, sel_ff}  :
                           hit_stat ? stat_word        :
                           hit_res  ? 32'(res_mem[res_idx]) : 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // channel decoder
  // ---------------------------------------------------------------------------
  asc_chan_map u_map (
    .code       (chan_ff),
    .special    (sel_ff[asc_pkg::SEL_SPECIAL]),
    .ext_onehot (CONV_EXT_SELECT),
    .ref_high   (CONV_REF_HIGH),
    .ref_low    (CONV_REF_LOW),
    .ref_mid    (CONV_REF_MID),
    .reserved   (CONV_RESERVED)
  );

  // ---------------------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------------------
  // restart outranks a done in the same cycle: that conversion was aborted
  always_comb begin
    nxt_state = state_ff;
    nxt_pos   = pos_ff;
    nxt_cnt   = cnt_ff;
    if (restart) begin
      nxt_state = asc_pkg::ST_START; // [R23]
      nxt_pos   = 3'h0;
      nxt_cnt   = fifo_mode ? cnt_ff : asc_pkg::RST_COUNT; // [R16] [R17]
    end else begin
      unique case (state_ff)
        asc_pkg::ST_IDLE: begin
          nxt_state = asc_pkg::ST_IDLE;
        end
        asc_pkg::ST_START: begin
          nxt_state = asc_pkg::ST_WAIT;
        end
        asc_pkg::ST_WAIT: begin
          if (done_ev) begin
            nxt_cnt = 3'(cnt_ff + 3'h1); // wraps seven to zero [R17]
            nxt_pos = 3'(pos_ff + 3'h1);
            if (last_conv) begin
              nxt_pos = 3'h0;
              // outside fifo the counter restarts with each sequence [R16]
              if (!fifo_mode) begin
                nxt_cnt = asc_pkg::RST_COUNT;
              end
              // scan repeats the identical sequence, else idle [R25]
              nxt_state = sel_ff[asc_pkg::SEL_SCAN] ? asc_pkg::ST_START : asc_pkg::ST_IDLE;
            end else begin
              nxt_state = asc_pkg::ST_START;
            end
          end
        end
        default: begin
          nxt_state = asc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // flag next values
  // ---------------------------------------------------------------------------
  // set beats clear in the same cycle so no completion is lost
  always_comb begin
    nxt_ccf   = ccf_ff;
    nxt_armed = armed_ff;
    nxt_scf   = scf_ff;
    if (restart) begin
      nxt_ccf   = 8'h00; // [R22]
      nxt_armed = 8'h00;
      nxt_scf   = 1'b0;  // [R15] [R22]
    end else begin
      if (stat_wr) begin
        nxt_ccf = AVS_WRITEDATA[7:0]; // [R21]
      end
      nxt_ccf   = (nxt_ccf & ~clr_mask) | set_mask; // [R18] [R19] [R20]
      // a status read arms the flags it showed as set
      nxt_armed = stat_rd ? ccf_ff : (armed_ff & ~clr_mask);
      nxt_armed = nxt_armed & ~set_mask;
      if (fast_clear && res_rd) begin
        nxt_scf = 1'b0; // [R15]
      end
      if (done_ev && last_conv) begin
        nxt_scf = 1'b1; // [R14]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // sequencer and flag registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= asc_pkg::ST_IDLE;
      pos_ff   <= 3'h0;
      cnt_ff   <= asc_pkg::RST_COUNT;
      ccf_ff   <= asc_pkg::RST_BYTE;
      armed_ff <= asc_pkg::RST_BYTE;
      scf_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pos_ff   <= nxt_pos;
      cnt_ff   <= nxt_cnt;
      ccf_ff   <= nxt_ccf;
      armed_ff <= nxt_armed;
      scf_ff   <= nxt_scf;
    end
  end

  // ---------------------------------------------------------------------------
  // conversion request outputs
  // ---------------------------------------------------------------------------
  // channel is latched at start so it holds steady through the conversion
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      chan_ff  <= 3'h0;
    end else begin
      start_ff <= state_ff[1] & ~restart;
      abort_ff <= restart & ~state_ff[0]; // cancel pending request [R22] [R23]
      if (state_ff[1]) begin
        chan_ff <= conv_code; // [R07]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // result storage
  // ---------------------------------------------------------------------------
  // result lands in the register the counter points at [R16] [R18]
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 8; i++) begin
        res_mem[i] <= RES_W'(asc_pkg::RST_RESULT);
      end
    end else if (done_ev && !restart) begin
      res_mem[cnt_ff] <= CONV_DATA;
    end
  end

  // ---------------------------------------------------------------------------
  // software registers and bus answer
  // ---------------------------------------------------------------------------
  // one wait cycle: read data is captured first, answered on the second
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_ff   <= asc_pkg::RST_BYTE;
      ctl4_ff  <= asc_pkg::RST_BYTE;
      sel_ff   <= asc_pkg::RST_BYTE;
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (AVS_READ && !ack_ff) begin
        rdata_ff <= rd_mux;
      end
      if (wr_take && hit_cfg) begin
        cfg_ff <= {5'h00, AVS_WRITEDATA[2:0]};
      end
      if (wr_take && hit_ctl4) begin
        ctl4_ff <= AVS_WRITEDATA[7:0];
      end
      if (wr_take && hit_sel) begin
        sel_ff <= AVS_WRITEDATA[7:0];
      end
    end
  end

  assign AVS_WAITREQUEST = bus_req & ~ack_ff;
  assign AVS_READDATA    = rdata_ff;
  assign CONV_START      = start_ff;
  assign CONV_ABORT      = abort_ff;
  assign CONV_CHANNEL    = chan_ff;
  assign SEQ_BUSY        = ~state_ff[0];

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_restart_clears: assert property (@(posedge CLK) disable iff (!RST_B) // [R22]
    restart |=> (ccf_ff == 8'h00) && !scf_ff)
    else $error("control write did not clear flags");
  a_restart_starts: assert property (@(posedge CLK) disable iff (!RST_B) // [R23]
    restart |=> state_ff == asc_pkg::ST_START ##1 CONV_START)
    else $error("control write did not start a sequence");
  a_single_chan: assert property (@(posedge CLK) disable iff (!RST_B) // [R01]
    (CONV_START && !multi && !$past(restart)) |-> CONV_CHANNEL == base_code)
    else $error("single mode converted another channel");
  a_multi_step: assert property (@(posedge CLK) disable iff (!RST_B) // [R02]
    (state_ff[1] && multi && !restart) |=> CONV_CHANNEL == 3'($past(base_code) + $past(pos_ff)))
    else $error("multi mode channel not start plus position");
  a_ccf_set: assert property (@(posedge CLK) disable iff (!RST_B) // [R18]
    (done_ev && !restart) |=> ccf_ff[$past(cnt_ff)] && res_mem[$past(cnt_ff)] == $past(CONV_DATA))
    else $error("complete flag or result missing");
  a_scf_set: assert property (@(posedge CLK) disable iff (!RST_B) // [R14]
    (done_ev && last_conv && !restart) |=> scf_ff)
    else $error("sequence flag not set at end");
  a_cnt_reset: assert property (@(posedge CLK) disable iff (!RST_B) // [R16]
    (restart && !fifo_mode) |=> cnt_ff == 3'h0)
    else $error("counter not reset at new sequence");
  a_scan_idle: assert property (@(posedge CLK) disable iff (!RST_B) // [R25]
    (done_ev && last_conv && !restart && !sel_ff[asc_pkg::SEL_SCAN]) |=> state_ff[0] && !CONV_START)
    else $error("sequence without scan did not go idle");
  a_status_ro: assert property (@(posedge CLK) disable iff (!RST_B) // [R13]
    (wr_take && hit_stat && !test_mode && !done_ev && !res_acc) |=> $stable(ccf_ff))
    else $error("status write changed flags outside test mode");
  a_fast_clear: assert property (@(posedge CLK) disable iff (!RST_B) // [R20]
    (res_rd && fast_clear && !restart && !(done_ev && cnt_ff == res_idx)) |=> !ccf_ff[$past(res_idx)])
    else $error("fast clear did not clear flag");
  a_len_one: assert property (@(posedge CLK) disable iff (!RST_B) // [R11]
    (done_ev && !sel_ff[asc_pkg::SEL_EIGHT] && sel_ff[asc_pkg::SEL_SINGLE]) |-> last_conv)
    else $error("single length sequence ran on");
  a_fifo_keep: assert property (@(posedge CLK) disable iff (!RST_B) // [R17]
    (restart && fifo_mode) |=> cnt_ff == $past(cnt_ff))
    else $error("fifo counter changed at new sequence");
  a_norm_clear: assert property (@(posedge CLK) disable iff (!RST_B) // [R19]
    (res_acc && !fast_clear && armed_ff[res_idx] && !restart && !(done_ev && cnt_ff == res_idx))
    |=> !ccf_ff[$past(res_idx)])
    else $error("armed flag not cleared by result access");
  a_ext_decode: assert property (@(posedge CLK) disable iff (!RST_B) // [R04]
    !sel_ff[asc_pkg::SEL_SPECIAL] |-> CONV_EXT_SELECT == (8'h01 << CONV_CHANNEL))
    else $error("external select does not match channel code");
  a_special_src: assert property (@(posedge CLK) disable iff (!RST_B) // [R05]
    sel_ff[asc_pkg::SEL_SPECIAL] |-> CONV_EXT_SELECT == 8'h00)
    else $error("external input selected in special mode");
  a_scan_again: assert property (@(posedge CLK) disable iff (!RST_B) // [R25]
    (done_ev && last_conv && !restart && sel_ff[asc_pkg::SEL_SCAN])
    |=> state_ff == asc_pkg::ST_START)
    else $error("scan did not restart the sequence");
endmodule : asc_seq_top

// [verification/asc_conv_model.sv]
// behavioural analog converter that answers the sequencer's start pulses
`timescale 1ns/10ps
module asc_conv_model (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [7:0]  ext_sel,
  input  wire logic        ref_high,
  input  wire logic        ref_low,
  input  wire logic        ref_mid,
  input  wire logic        reserved,
  input  wire logic [7:0]  gap,
  output logic             done,
  output logic      [15:0] data
);
  logic [15:0] val; // result of the conversion in flight
  logic        cut; // conversion cancelled by the sequencer
  int          n;   // cycles spent converting
  // --------------------------------------------------------------------
  // one done per start after gap cycles, none if the start is aborted; data is junk outside done
  // --------------------------------------------------------------------
  initial begin
    done = 1'b0;
    data = 16'h0000;
    forever begin
      @(posedge clk);
      if (start) begin
        // internal sources first: external select must be idle then
        val = ref_high ? {8'h00, asc_pkg::EXP_HIGH} : ref_low ? {8'h00, asc_pkg::EXP_LOW} :
              ref_mid ? {8'h00, asc_pkg::EXP_MID} : reserved ? 16'hEEEE : {8'hA5, ext_sel};
        cut = 1'b0;
        for (n = 0; n < gap && !cut; n++) begin
          @(posedge clk);
          cut = abort; // leave at once so the restart pulse is not missed
        end
        if (!cut) begin
          done <= 1'b1;
          data <= val;
          @(posedge clk);
          done <= 1'b0;
          data <= ~val; // no stale value after the strobe
        end
      end
    end
  end
endmodule : asc_conv_model

// [verification/tb_adc_sequence_channel_status.sv]
// self-checking bench for the conversion sequence controller
`timescale 1ns/10ps
module tb_adc_sequence_channel_status;
  // --------------------------------------------------------------------
  // signals and scoreboard
  // --------------------------------------------------------------------
  logic        clk, done, start, abort, busy, wreq, r_hi, r_lo, r_md, r_rs;
  logic        rst_b = 1'b0;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [3:0]  addr  = 4'h0;
  logic [31:0] wdat  = 32'h0, seed = 32'h24D2;
  logic [7:0]  gap   = 8'h02, esel;
  logic [31:0] rdat, expq[$], mskq[$]; // notes waiting for read answers
  logic [2:0]  chan, c;
  logic [15:0] data;
  int          bad_count = 0, total_checks = 0, k;
  localparam logic [31:0] NOCNT = 32'hFFFF_F8FF; // hides the result counter
  localparam logic [3:0]  R0 = asc_pkg::IDX_RESULT0;
  localparam logic [3:0]  ST = asc_pkg::IDX_STATUS;
  localparam logic [3:0]  CF = asc_pkg::IDX_CONFIG;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  asc_seq_top DUT (.CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .CONV_START(start), .CONV_ABORT(abort), .CONV_CHANNEL(chan), .CONV_EXT_SELECT(esel),
    .CONV_REF_HIGH(r_hi), .CONV_REF_LOW(r_lo), .CONV_REF_MID(r_md), .CONV_RESERVED(r_rs),
    .CONV_DONE(done), .CONV_DATA(data), .SEQ_BUSY(busy));
  asc_conv_model conv (.clk(clk), .start(start), .abort(abort), .ext_sel(esel),
    .ref_high(r_hi), .ref_low(r_lo), .ref_mid(r_md), .reserved(r_rs), .gap(gap),
    .done(done), .data(data));
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [31:0] ex(input logic [2:0] ch); // external result word
    return {16'h0000, 8'hA5, 8'h01 << ch};
  endfunction : ex
  function automatic logic [31:0] st(input logic s, input logic [2:0] n, input logic [7:0] f);
    return {16'h0000, s, 4'h0, n, f};
  endfunction : st
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdat <= d;
    rd   <= ~w;
    wr   <= w;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) bad_count++; // slave never answered
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk); // keeps two strobes out of one time step
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expq.push_back(e & m);
    mskq.push_back(m);
    bus(a, 1'b0, 32'h0);
  endtask : rdc
  // start a sequence and wait for the sequencer to go idle
  task automatic run(input logic [7:0] s);
    int n;
    n = 0;
    bus(asc_pkg::IDX_SELECT, 1'b1, {24'h0, s});
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) bad_count++;
  endtask : run
  task automatic final_report();
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // the monitor takes the oldest note at every answered read
  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && expq.size() > 0) begin
      check("readdata", rdat & mskq.pop_front(), expq.pop_front());
    end
    if (start && !r_hi && !r_lo && !r_md && !r_rs)
      check("channel", {24'h0, esel}, {24'h0, 8'h01 << chan});
  end
  initial begin
    #50000;
    bad_count++; // hang
    final_report();
  end
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 5; k++) rdc(4'(k), 32'h0, '1);
    bus(CF, 1'b1, 32'h1); // fifo: counter carries over
    run(8'h83);
    run(8'h84);
    rdc(R0, ex(3'd3), '1);
    rdc(R0 + 4'h1, ex(3'd4), '1);
    run(8'h50);
    for (k = 0; k < 8; k++) rdc(R0 + 4'((k + 2) % 8), ex(3'(k)), '1);
    rdc(ST, st(1'b1, 3'd2, 8'hFF), '1);
    bus(CF, 1'b1, 32'h0);
    run(8'h16); // single bit clear for a four-long sequence
    rdc(R0 + 4'h3, ex(3'd1), '1);
    rdc(ST, st(1'b1, 3'd0, 8'h0F), NOCNT);
    for (k = 0; k < 3; k++) rdc(R0 + 4'(k), ex(3'(k + 6)), '1);
    rdc(ST, st(1'b1, 3'd0, 8'h08), NOCNT);
    bus(ST, 1'b1, 32'h0000_00FF);
    rdc(ST, st(1'b1, 3'd0, 8'h08), NOCNT);
    bus(CF, 1'b1, 32'h4);
    bus(ST, 1'b1, 32'h0000_80A5);
    rdc(ST, st(1'b1, 3'd0, 8'hA5), NOCNT);
    bus(CF, 1'b1, 32'h0);
    gap <= 8'd40; // slow conversion so the select write of run(8'h83) lands mid-sequence
    bus(asc_pkg::IDX_CONTROL4, 1'b1, 32'h0);
    rdc(ST, 32'h0, NOCNT);
    run(8'h83);
    rdc(R0, ex(3'd3), '1);
    rdc(ST, st(1'b1, 3'd0, 8'h01), NOCNT);
    seed = xs(seed);
    gap <= {5'h0, seed[2:0]} + 8'h01;
    run(8'h45);
    for (k = 0; k < 8; k++) rdc(R0 + 4'(k), ex(3'd5), '1);
    seed = xs(seed);
    c = seed[2:0];
    run({5'b01010, c});
    for (k = 0; k < 8; k++) rdc(R0 + 4'(k), ex(c + 3'(k)), '1);
    run(8'h1C); // special sources: high, low, mid, then reserved
    rdc(R0, 32'h00FF, '1);
    rdc(R0 + 4'h1, 32'h0000, '1);
    rdc(R0 + 4'h2, 32'h007F, '1);
    rdc(R0 + 4'h3, 32'hEEEE, '1);
    run(8'h89);
    rdc(R0, 32'hEEEE, '1);
    bus(CF, 1'b1, 32'h2);
    run(8'h82); // unused code bits left at zero
    rdc(R0, ex(3'd2), '1);
    rdc(ST, 32'h0, NOCNT);
    bus(CF, 1'b1, 32'h0);
    bus(asc_pkg::IDX_SELECT, 1'b1, 32'hA7);
    repeat (60) @(posedge clk);
    check("busy", {31'h0, busy}, 32'h1);
    rdc(ST, st(1'b1, 3'd0, 8'h01), NOCNT);
    run(8'h86);
    rdc(R0, ex(3'd6), '1);
    final_report();
  end
endmodule : tb_adc_sequence_channel_status
